// >>> ebt_trigger.sv
// Event break and trace trigger logic with an AHB-Lite register slave.
//
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ebt_defines.svh"
module ebt_trigger (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic cpu_running,
   input wire logic cpu_reset,
   input wire ebt_pkg::ebt_acc_t acc,
   input wire ebt_pkg::ebt_br_t br,
   input wire logic [7:0] a_hit,
   input wire logic [7:0] b_hit,
   output logic break_req,
   output logic irq
);
   // ==========================================================
   // State
   ebt_pkg::ebt_cfg_t cfg_reg, cfg_next;
   logic [7:0] evsel_reg, evsel_next;
   logic [3:0] stat_reg, stat_next, mask_reg, mask_next;
   logic run_reg, seen_a_reg, seen_a_next, seen_b_reg, seen_b_next, pend_reg, pend_next;
   ebt_pkg::ebt_tr_t tr_reg, tr_next;
   logic [`EBT_CNTW-1:0] cnt_reg, cnt_next;
   logic [`EBT_TAW-1:0] wptr_reg, wptr_next, tidx_reg, tidx_next;
   logic wr_reg, wr_next;
   logic [7:0] dadr_reg, dadr_next;
   logic [31:0] hrdata_next;
   logic brk_next, irq_next;
   logic [31:0] mem [`EBT_TDEPTH];
   logic a_m, b_m, both, seq, go, halt, start_ev, stop_ev, full, full_ev, rec, wr_en;
   logic ap;
   logic [31:0] entry;

   // ==========================================================
   // Condition evaluation
   function automatic logic fire(input ebt_pkg::ebt_cond_t sel, input logic a, input logic b,
                                 input logic ab, input logic ba);
      case (sel)
         ebt_pkg::COND_A: fire = a;
         ebt_pkg::COND_A_OR_B: fire = a | b;
         ebt_pkg::COND_A_AND_B: fire = ab;
         ebt_pkg::COND_B_THEN_A: fire = ba;
         default: fire = 1'b0;
      endcase
   endfunction : fire

   always_comb
   begin
      // Each channel matches only through its single selected setting.
      a_m = acc.valid & ~acc.by_xfer & evsel_reg[`EBT_EVSEL_A_EN] & a_hit[evsel_reg[2:0]];
      b_m = acc.valid & ~acc.by_xfer & evsel_reg[`EBT_EVSEL_B_EN]
            & b_hit[evsel_reg[`EBT_EVSEL_B_LSB +: 3]];
      both = (seen_a_reg | a_m) & (seen_b_reg | b_m) & (a_m | b_m);
      seq = a_m & pend_reg;
      go = cpu_running & ~run_reg;
      halt = ~cpu_running & run_reg;
      full = cnt_reg == `EBT_CNTW'(`EBT_TDEPTH);
      if (cfg_reg.start == ebt_pkg::COND_NONE)
         start_ev = go;
      else
         start_ev = fire(cfg_reg.start, a_m, b_m, both, seq);
      case (cfg_reg.stop)
         ebt_pkg::COND_NONE: stop_ev = halt;
         ebt_pkg::COND_FULL: stop_ev = full;
         default: stop_ev = fire(cfg_reg.stop, a_m, b_m, both, seq);
      endcase
      if (cfg_reg.ttype)
         rec = cfg_reg.pick ? (a_m | b_m) : a_m;
      else
         rec = br.valid;
      // The old trace state gates storage, so the starting access is dropped.
      // Under the full stop a full store takes no further entry, so none is overwritten.
      wr_en = (tr_reg == ebt_pkg::TR_ON) & rec & ~cpu_reset
              & ~(full & (cfg_reg.stop == ebt_pkg::COND_FULL));
      entry = cfg_reg.ttype ? {acc.addr, acc.data} : {br.src, br.dst};
      full_ev = wr_en & (cnt_reg == `EBT_CNTW'(`EBT_TDEPTH - 1));
   end

   // ==========================================================
   // Trigger, trace and register next state
   always_comb
   begin
      ap = hsel & htrans[1] & hready;
      cfg_next = cfg_reg;
      evsel_next = evsel_reg;
      mask_next = mask_reg;
      tidx_next = tidx_reg;
      stat_next = stat_reg;
      hrdata_next = 32'h0000_0000;
      wr_next = ap & hwrite;
      dadr_next = ap ? haddr[7:0] : dadr_reg;
      tr_next = tr_reg;
      if (cpu_reset)
      begin
         seen_a_next = 1'b0;
         seen_b_next = 1'b0;
         pend_next = 1'b0;
      end
      else
      begin
         seen_a_next = (seen_a_reg & ~go) | a_m;
         seen_b_next = (seen_b_reg & ~go) | b_m;
         pend_next = (pend_reg & ~go) | b_m;
      end
      case (tr_reg)
         ebt_pkg::TR_IDLE:
            if (start_ev & ~cpu_reset)
               tr_next = ebt_pkg::TR_ON;
         ebt_pkg::TR_ON:
            if (cpu_reset | (stop_ev & ~start_ev))
               tr_next = ebt_pkg::TR_IDLE;
         default: tr_next = ebt_pkg::TR_IDLE;
      endcase
      if (cpu_reset)
      begin
         cnt_next = '0;
         wptr_next = '0;
      end
      else
      begin
         cnt_next = cnt_reg + `EBT_CNTW'(wr_en & ~full);
         wptr_next = wptr_reg + `EBT_TAW'(wr_en);
      end
      brk_next = cpu_running & (fire(cfg_reg.brk, a_m, b_m, both, seq)
                 | (cfg_reg.full_brk & full_ev));
      if (ap & ~hwrite)
      begin
         case (haddr[7:0])
            `EBT_CTRL_OFF: hrdata_next = {20'h0_0000, cfg_reg};
            `EBT_EVSEL_OFF: hrdata_next = {24'h00_0000, evsel_reg};
            `EBT_STAT_OFF:
            begin
               hrdata_next = {28'h000_0000, stat_reg};
               stat_next = 4'h0;
            end
            `EBT_MASK_OFF: hrdata_next = {28'h000_0000, mask_reg};
            `EBT_STATE_OFF: hrdata_next = {23'h00_0000, cnt_reg, tr_reg, pend_reg, seen_b_reg,
                                           seen_a_reg};
            `EBT_TIDX_OFF: hrdata_next = {28'h000_0000, tidx_reg};
            `EBT_TDATA_OFF: hrdata_next = (`EBT_CNTW'(tidx_reg) < cnt_reg) ? mem[tidx_reg]
                                          : 32'h0000_0000;
            default: hrdata_next = 32'h0000_0000;
         endcase
      end
      if (wr_reg)
      begin
         case (dadr_reg)
            `EBT_CTRL_OFF:
            begin
               cfg_next.brk = ebt_pkg::ebt_cond_t'(hwdata[`EBT_CTRL_BRK_LSB +: 3]);
               cfg_next.full_brk = hwdata[`EBT_CTRL_FULLBRK];
               cfg_next.ttype = hwdata[`EBT_CTRL_TTYPE];
               cfg_next.start = ebt_pkg::ebt_cond_t'(hwdata[`EBT_CTRL_START_LSB +: 3]);
               cfg_next.stop = ebt_pkg::ebt_cond_t'(hwdata[`EBT_CTRL_STOP_LSB +: 3]);
               cfg_next.pick = hwdata[`EBT_CTRL_PICK];
            end
            `EBT_EVSEL_OFF: evsel_next = hwdata[7:0];
            `EBT_MASK_OFF: mask_next = hwdata[3:0];
            `EBT_TIDX_OFF: tidx_next = hwdata[`EBT_TAW-1:0];
            default: ;
         endcase
      end
      // Hardware events win over the clear-on-read.
      stat_next[`EBT_ST_BRK] = stat_next[`EBT_ST_BRK] | brk_next;
      stat_next[`EBT_ST_FULL] = stat_next[`EBT_ST_FULL] | full_ev;
      stat_next[`EBT_ST_START] = stat_next[`EBT_ST_START]
                                 | (tr_reg == ebt_pkg::TR_IDLE && tr_next == ebt_pkg::TR_ON);
      stat_next[`EBT_ST_STOP] = stat_next[`EBT_ST_STOP]
                                | (tr_reg == ebt_pkg::TR_ON && tr_next == ebt_pkg::TR_IDLE);
      irq_next = |(stat_next & mask_next);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cfg_reg <= `EBT_RST_CTRL;
         evsel_reg <= `EBT_RST_EVSEL;
         stat_reg <= 4'h0;
         mask_reg <= `EBT_RST_MASK;
         run_reg <= 1'b0;
         seen_a_reg <= 1'b0;
         seen_b_reg <= 1'b0;
         pend_reg <= 1'b0;
         tr_reg <= ebt_pkg::TR_IDLE;
         cnt_reg <= '0;
         wptr_reg <= '0;
         tidx_reg <= '0;
         wr_reg <= 1'b0;
         dadr_reg <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         break_req <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         cfg_reg <= cfg_next;
         evsel_reg <= evsel_next;
         stat_reg <= stat_next;
         mask_reg <= mask_next;
         run_reg <= cpu_running;
         seen_a_reg <= seen_a_next;
         seen_b_reg <= seen_b_next;
         pend_reg <= pend_next;
         tr_reg <= tr_next;
         cnt_reg <= cnt_next;
         wptr_reg <= wptr_next;
         tidx_reg <= tidx_next;
         wr_reg <= wr_next;
         dadr_reg <= dadr_next;
         hrdata <= hrdata_next;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         break_req <= brk_next;
         irq <= irq_next;
      end
   end

   // The trace store needs no reset; the entry count hides stale words.
   always_ff @(posedge hclk)
   begin
      if (wr_en)
         mem[wptr_reg] <= entry;
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_brk_cause: assert property (break_req |->
      $past(cfg_reg.brk) != ebt_pkg::COND_NONE || $past(cfg_reg.full_brk))
      else $error("break without an enabled break source");
   a_seq_order: assert property ((cfg_reg.brk == ebt_pkg::COND_B_THEN_A && !cfg_reg.full_brk
      && !pend_reg) |=> !break_req)
      else $error("sequential break fired without prior B");
   a_and_both: assert property ((cfg_reg.brk == ebt_pkg::COND_A_AND_B && !cfg_reg.full_brk
      && !(seen_b_reg | b_m)) |=> !break_req)
      else $error("and break fired without B");
   a_full_brk: assert property (full_ev && cfg_reg.full_brk && cpu_running |=> break_req
      && stat_reg[`EBT_ST_BRK])
      else $error("trace full break missing");
   a_start_skip: assert property (tr_reg == ebt_pkg::TR_IDLE |-> !wr_en)
      else $error("access stored before trace started");
   a_same_cycle: assert property (tr_reg == ebt_pkg::TR_ON && start_ev && !cpu_reset
      |=> tr_reg == ebt_pkg::TR_ON)
      else $error("stop not ignored on simultaneous start");
   // The stop checks leave out cycles in which the start condition also holds.
   a_full_stop: assert property (cfg_reg.stop == ebt_pkg::COND_FULL && full && !start_ev
      && tr_reg == ebt_pkg::TR_ON |=> tr_reg == ebt_pkg::TR_IDLE)
      else $error("trace did not stop when full");
   a_full_hold: assert property (cfg_reg.stop == ebt_pkg::COND_FULL && full
      |-> !wr_en)
      else $error("store taken while the full stop holds");
   a_go_start: assert property (cfg_reg.start == ebt_pkg::COND_NONE && go
      && tr_reg == ebt_pkg::TR_IDLE && !cpu_reset |=> tr_reg == ebt_pkg::TR_ON)
      else $error("trace did not start on program start");
   a_halt_stop: assert property (cfg_reg.stop == ebt_pkg::COND_NONE && halt
      && !start_ev && tr_reg == ebt_pkg::TR_ON |=> tr_reg == ebt_pkg::TR_IDLE)
      else $error("trace did not stop on program halt");
   a_pick_a: assert property (wr_en && cfg_reg.ttype && !cfg_reg.pick |-> a_m)
      else $error("non A access stored in data mode");
   a_no_xfer: assert property (wr_en && cfg_reg.ttype |-> !acc.by_xfer)
      else $error("transfer controller access traced");
   a_reset_clr: assert property (cpu_reset |=> cnt_reg == '0 && !seen_a_reg && !pend_reg
      && tr_reg == ebt_pkg::TR_IDLE)
      else $error("processor reset did not clear trace state");
   a_cnt_step: assert property (wr_en && !full |=> cnt_reg == $past(cnt_reg) + 1'b1)
      else $error("trace count did not advance");

   c_seq_brk: cover property (pend_reg && a_m && cfg_reg.brk == ebt_pkg::COND_B_THEN_A);
   c_full: cover property (full_ev);
   c_start_stop: cover property (tr_reg == ebt_pkg::TR_ON ##[1:20] tr_reg == ebt_pkg::TR_IDLE);
   c_irq: cover property (irq);
   c_and_brk: cover property (both && cfg_reg.brk == ebt_pkg::COND_A_AND_B);
endmodule : ebt_trigger

// >>> ebt_defines.svh
// Register offsets, field positions, reset values and sizes of the event trigger.
`ifndef EBT_DEFINES_SVH
`define EBT_DEFINES_SVH
`define EBT_CTRL_OFF 8'h00
`define EBT_EVSEL_OFF 8'h04
`define EBT_STAT_OFF 8'h08
`define EBT_MASK_OFF 8'h0C
`define EBT_STATE_OFF 8'h10
`define EBT_TIDX_OFF 8'h14
`define EBT_TDATA_OFF 8'h18
`define EBT_CTRL_BRK_LSB 0
`define EBT_CTRL_FULLBRK 3
`define EBT_CTRL_TTYPE 4
`define EBT_CTRL_START_LSB 5
`define EBT_CTRL_STOP_LSB 8
`define EBT_CTRL_PICK 11
`define EBT_EVSEL_A_EN 3
`define EBT_EVSEL_B_LSB 4
`define EBT_EVSEL_B_EN 7
`define EBT_ST_BRK 0
`define EBT_ST_FULL 1
`define EBT_ST_START 2
`define EBT_ST_STOP 3
`define EBT_RST_CTRL 12'h000
`define EBT_RST_EVSEL 8'h00
`define EBT_RST_MASK 4'h0
`define EBT_TDEPTH 16
`define EBT_TAW 4
`define EBT_CNTW 5
`endif

// >>> ebt_pkg.sv
// Types shared by the event trigger design.
package ebt_pkg;
   typedef enum logic [2:0] {COND_NONE, COND_A, COND_A_OR_B, COND_A_AND_B, COND_B_THEN_A,
                             COND_FULL} ebt_cond_t;
   typedef enum logic {TR_IDLE, TR_ON} ebt_tr_t;
   typedef struct packed {
      logic pick;
      ebt_cond_t stop;
      ebt_cond_t start;
      logic ttype;
      logic full_brk;
      ebt_cond_t brk;
   } ebt_cfg_t;
   typedef struct packed {
      logic valid;
      logic by_xfer;
      logic [15:0] addr;
      logic [15:0] data;
   } ebt_acc_t;
   typedef struct packed {
      logic valid;
      logic [15:0] src;
      logic [15:0] dst;
   } ebt_br_t;
endpackage : ebt_pkg

// >>> ebt_cpu_model.sv
// Behavioural model of the monitored processor core and its CPU bus.
`timescale 1ns/1ps
module ebt_cpu_model (
   input wire logic hclk,
   input wire logic break_req,
   output logic cpu_running,
   output logic cpu_reset,
   output ebt_pkg::ebt_acc_t acc,
   output ebt_pkg::ebt_br_t br,
   output logic [7:0] a_hit,
   output logic [7:0] b_hit
);
   int breaks = 0;
   // Puts the core at rest with an idle bus; the bench calls it once at the start.
   task automatic idle;
      cpu_running <= 1'b0;
      cpu_reset <= 1'b0;
      acc <= '0;
      br <= '0;
      a_hit <= 8'h00;
      b_hit <= 8'h00;
   endtask : idle
   // ==================================================
   // Core behaviour
   // A halt request stops the user program at the next edge.
   always @(posedge hclk)
      if (break_req === 1'b1)
      begin
         breaks <= breaks + 1;
         cpu_running <= 1'b0;
      end
   task automatic run(input logic r);
      @(posedge hclk);
      cpu_running <= r;
   endtask : run
   // Idle cycles show inverted values, so a stale access cannot pass for a new one.
   task automatic access(input logic [15:0] ad, input logic [15:0] dt, input logic [7:0] ah,
      input logic [7:0] bh, input logic xf);
      @(posedge hclk);
      acc <= {1'b1, xf, ad, dt};
      a_hit <= ah;
      b_hit <= bh;
      @(posedge hclk);
      acc <= {1'b0, ~xf, ~ad, ~dt};
      a_hit <= ~ah;
      b_hit <= ~bh;
   endtask : access
   task automatic branch(input logic [15:0] s, input logic [15:0] d);
      @(posedge hclk);
      br <= {1'b1, s, d};
      @(posedge hclk);
      br <= {1'b0, ~s, ~d};
   endtask : branch
   task automatic rst;
      @(posedge hclk);
      cpu_reset <= 1'b1;
      @(posedge hclk);
      cpu_reset <= 1'b0;
   endtask : rst
endmodule : ebt_cpu_model

// >>> event_break_trace_trigger_test.sv
// Self-checking bench for the event break and trace trigger.
`timescale 1ns/1ps
module event_break_trace_trigger_test;
   logic hclk = 1'b0;
   logic hresetn, hsel, hwrite;
   logic [31:0] haddr, hwdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, hresp, cpu_running, cpu_reset, break_req, irq;
   logic [31:0] hrdata, rd;
   logic [7:0] a_hit, b_hit;
   ebt_pkg::ebt_acc_t acc;
   ebt_pkg::ebt_br_t br;
   int num_errors = 0;
   int num_checks = 0;
   int base;
   always #2 hclk = ~hclk;
   ebt_trigger u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cpu_running(cpu_running),
      .cpu_reset(cpu_reset), .acc(acc), .br(br), .a_hit(a_hit), .b_hit(b_hit),
      .break_req(break_req), .irq(irq));
   ebt_cpu_model u_cpu (.hclk(hclk), .break_req(break_req), .cpu_running(cpu_running),
      .cpu_reset(cpu_reset), .acc(acc), .br(br), .a_hit(a_hit), .b_hit(b_hit));
   // ==================================================
   // Shared tasks
   task automatic complete_run;
      $display("errors %0d checks %0d", num_errors, num_checks);
      if (num_errors == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   endtask : check_reg
   task automatic check_brk(input int exp);
      num_checks++;
      if (u_cpu.breaks - base != exp)
      begin
         num_errors++;
         $display("[ERR] %0t halt requests %0d expected %0d", $time, u_cpu.breaks - base, exp);
      end
   endtask : check_brk
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
   endtask : wr
   task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0);
      check_reg(rd & m, exp);
   endtask : rdm
   task automatic entry(input logic [31:0] i, input logic [31:0] exp);
      wr(8'h14, i);
      rdm(8'h18, 32'hFFFFFFFF, exp);
   endtask : entry
   task automatic settle;
      repeat (3) @(posedge hclk);
   endtask : settle
   task automatic hit(input logic [7:0] ah, input logic [7:0] bh);
      u_cpu.access(16'h0100, 16'h0011, ah, bh, 1'b0);
      settle();
   endtask : hit
   task automatic fill(input int n);
      for (int i = 0; i < n; i++)
         u_cpu.branch(i[15:0], ~i[15:0]);
      settle();
   endtask : fill
   // ==================================================
   // Scenarios
   task automatic t_regs;
      rdm(8'h00, 32'hFFFFFFFF, 32'h0);
      rdm(8'h04, 32'hFFFFFFFF, 32'h0);
      rdm(8'h1C, 32'hFFFFFFFF, 32'h0);
   endtask : t_regs
   task automatic t_break_a;
      wr(8'h0C, 32'h1);
      wr(8'h04, 32'h0A);
      wr(8'h04, 32'h0B);
      wr(8'h00, 32'h1);
      base = u_cpu.breaks;
      u_cpu.run(1'b1);
      hit(8'h04, 8'h00);
      check_brk(0);
      hit(8'h08, 8'h00);
      check_brk(1);
      check_reg({31'h0, irq}, 32'h1);
      rdm(8'h08, 32'h1, 32'h1);
      settle();
      check_reg({31'h0, irq}, 32'h0);
   endtask : t_break_a
   task automatic t_seq;
      wr(8'h04, 32'hDA);
      wr(8'h00, 32'h4);
      base = u_cpu.breaks;
      u_cpu.run(1'b1);
      hit(8'h04, 8'h00);
      hit(8'h04, 8'h20);
      check_brk(0);
      hit(8'h00, 8'h20);
      u_cpu.run(1'b0);
      u_cpu.run(1'b1);
      hit(8'h04, 8'h00);
      check_brk(0);
      hit(8'h00, 8'h20);
      hit(8'h04, 8'h00);
      check_brk(1);
      wr(8'h00, 32'h3);
      u_cpu.run(1'b1);
      hit(8'h04, 8'h00);
      check_brk(1);
      hit(8'h00, 8'h20);
      check_brk(2);
      wr(8'h00, 32'h2);
      u_cpu.run(1'b1);
      hit(8'h00, 8'h20);
      check_brk(3);
   endtask : t_seq
   task automatic t_branch;
      wr(8'h00, 32'h0);
      u_cpu.rst();
      u_cpu.run(1'b1);
      u_cpu.branch(16'h1234, 16'h5678);
      u_cpu.branch(16'h9ABC, 16'hDEF0);
      hit(8'h04, 8'h00);
      u_cpu.run(1'b0);
      u_cpu.branch(16'h1111, 16'h2222);
      rdm(8'h10, 32'h1F0, 32'h20);
      entry(32'h0, 32'h12345678);
      entry(32'h1, 32'h9ABCDEF0);
      u_cpu.run(1'b1);
      u_cpu.rst();
      rdm(8'h10, 32'h1F7, 32'h0);
   endtask : t_branch
   task automatic t_data;
      wr(8'h00, 32'h30);
      u_cpu.rst();
      u_cpu.run(1'b1);
      hit(8'h04, 8'h00);
      u_cpu.access(16'h0200, 16'h00BB, 8'h00, 8'h20, 1'b0);
      u_cpu.access(16'h0300, 16'h00CC, 8'h04, 8'h00, 1'b1);
      u_cpu.access(16'h0400, 16'h00DD, 8'h04, 8'h00, 1'b0);
      settle();
      rdm(8'h10, 32'h1F0, 32'h10);
      entry(32'h0, 32'h040000DD);
      wr(8'h00, 32'h830);
      u_cpu.rst();
      u_cpu.run(1'b1);
      hit(8'h04, 8'h00);
      u_cpu.access(16'h0200, 16'h00BB, 8'h00, 8'h20, 1'b0);
      settle();
      entry(32'h0, 32'h020000BB);
      wr(8'h00, 32'h130);
      u_cpu.rst();
      u_cpu.run(1'b1);
      hit(8'h04, 8'h00);
      rdm(8'h10, 32'h8, 32'h8);
   endtask : t_data
   task automatic t_full;
      wr(8'h00, 32'h500);
      u_cpu.rst();
      base = u_cpu.breaks;
      u_cpu.run(1'b0);
      u_cpu.run(1'b1);
      fill(17);
      check_brk(0);
      entry(32'h0, 32'h0000FFFF);
      rdm(8'h08, 32'h2, 32'h2);
      wr(8'h00, 32'h8);
      u_cpu.rst();
      u_cpu.run(1'b0);
      u_cpu.run(1'b1);
      fill(16);
      check_brk(1);
   endtask : t_full
   initial
   begin
      hresetn <= 1'b0;
      hsel <= 1'b0;
      haddr <= 32'h0000_0000;
      htrans <= 2'h0;
      hwrite <= 1'b0;
      hsize <= 3'h0;
      hwdata <= 32'h0000_0000;
      u_cpu.idle();
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_break_a();
      t_seq();
      t_branch();
      t_data();
      t_full();
      complete_run();
   end
   initial
   begin
      #100000;
      num_errors++;
      complete_run();
   end
endmodule : event_break_trace_trigger_test
